// file: video_switch_pkg.sv
package video_switch_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          REG_COUNT    = 8;
  localparam logic [7:0]  ADDR_HS_MODE = 8'h00;
  localparam logic [7:0]  ADDR_AUX     = 8'h01;
  localparam logic [7:0]  ADDR_RX      = 8'h10;
  localparam logic [7:0]  ADDR_PULSE1  = 8'h11;
  localparam logic [7:0]  ADDR_PULSE2  = 8'h12;
  localparam logic [7:0]  ADDR_EQ_AB   = 8'h13;
  localparam logic [7:0]  ADDR_EQ_CD   = 8'h14;
  localparam logic [7:0]  ADDR_TX      = 8'h20;
  // Byte i of each packed word belongs to register index i.
  localparam logic [63:0] REG_ADDRS    = {ADDR_TX, ADDR_EQ_CD, ADDR_EQ_AB, ADDR_PULSE2,
                                          ADDR_PULSE1, ADDR_RX, ADDR_AUX, ADDR_HS_MODE};
  localparam logic [63:0] REG_RESET    = 64'h0300_0000_0001_4040;
  localparam logic [63:0] REG_MASK     = 64'h0FFF_FFFF_FF01_4343;

  localparam int IDX_HS    = 0;
  localparam int IDX_AUX   = 1;
  localparam int IDX_RX    = 2;
  localparam int IDX_PT1   = 3;
  localparam int IDX_PT2   = 4;
  localparam int IDX_EQ_AB = 5;
  localparam int IDX_EQ_CD = 6;
  localparam int IDX_TX    = 7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ENABLE_BIT  = 6;
  localparam int SRC_LSB     = 0;
  localparam int TERM_IN_BIT = 0;
  localparam int EMPH_LSB    = 2;
  localparam int OTERM_BIT   = 1;
  localparam int CURR_BIT    = 0;

  // Boost bit: 0 is the 6 dB setting, 1 the 12 dB setting.
  localparam logic BOOST_LOW  = 1'b0;
  localparam logic BOOST_HIGH = 1'b1;
  // Emphasis codes: 0 dB, 2 dB, 4 dB, 6 dB.
  localparam logic [1:0] EMPH_NONE = 2'h0;
  localparam logic [1:0] EMPH_HIGH = 2'h3;
  // Drive current bit: 0 is 10 mA, 1 is 20 mA.
  localparam logic CURR_10MA = 1'b0;
  localparam logic CURR_20MA = 1'b1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int UPDATE_DELAY_DEFAULT = 16;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       strapHighspeedEnable;
    logic [1:0] strapSourceSelect;
    logic       strapBoostSelect;
    logic [1:0] strapEmphasisLevel;
    logic       strapOutputTermEnable;
    logic       strapDriveCurrentSel;
  } strap_pins_t;

  // Per-input fields are ordered {D, C, B, A}, each nibble lane 3 down to 0.
  typedef struct packed {
    logic        hsEnable;
    logic [1:0]  hsSource;
    logic        auxEnable;
    logic [1:0]  commonSideLinesSource;
    logic        inputTermEnable;
    logic [15:0] termPulseOnSwitch;
    logic [15:0] laneBoostSelect;
    logic [1:0]  outputEmphasisLevel;
    logic        outputTermEnable;
    logic        outputDriveCurrentSel;
  } switch_cfg_t;

endpackage

// file: video_switch_config_regs.sv
`timescale 1ns/100ps
// Functional notes
// RULE1: Boost bit clear selects 6 dB, set selects 12 dB.
// RULE2: Bits 0-3 B lanes 0-3, 4-7 A, 8-11 C lanes 3-0, 12-15 D.
// RULE3: Two-bit emphasis for all outputs: 0, 2, 4, 6 dB.
// RULE4: One output termination bit for all lanes; 1 connects terminations.
// RULE5: One drive current bit for all lanes; 0 is 10 mA, 1 20 mA.
// RULE6: Strap pins count only after reset and before any serial access.
// RULE7: Parallel register values follow the strap pins directly, no strobe.
// RULE8: Strap enable low puts fast lanes in standby, high switches on.
// RULE9: Strap source select routes input A to D to the outputs.
// RULE10: Parallel mode forces side switch on, same select routes side lines.
// RULE11: Parallel mode holds input termination enabled.
// RULE12: Parallel mode forces all sixteen termination pulse bits to zero.
// RULE13: One strap boost pin drives all sixteen boost bits.
// RULE14: Parallel transmitter byte: emphasis 3:2, termination 1, current 0.
// RULE15: Strap current pin low 10 mA, high 20 mA, all lanes.
// RULE16: First serial event switches to serial values until next reset.
// RULE17: Change applied when its update window ends; writes never restart it. A write with no window running is applied at once and opens the window.
// RULE18: Host reaches boost registers at 0x13, 0x14, transmitter at 0x20.
// RULE19: Outputs come from a mux of parallel or serial register sets.
module video_switch_config_regs #(
  parameter int UPDATE_DELAY = video_switch_pkg::UPDATE_DELAY_DEFAULT
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          serWrite,
  input  wire logic                          serRead,
  input  wire logic [7:0]                    serAddr,
  input  wire logic [7:0]                    serWData,
  output logic      [7:0]                    serRData,
  input  wire video_switch_pkg::strap_pins_t strapPins,
  output video_switch_pkg::switch_cfg_t      cfg,
  output logic                               serialMode
);
  import video_switch_pkg::*;

  localparam int CW = $clog2(UPDATE_DELAY + 1);

  if (UPDATE_DELAY < 1)
  begin : g_delayCheck
    $error("UPDATE_DELAY must be at least one cycle.");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] regIndex(input logic [7:0] addr);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < REG_COUNT; i++)
      if (REG_ADDRS[i*8 +: 8] == addr)
        r = {1'b1, 3'(i)};
    return r;
  endfunction

  // Reorders sixteen register bits into {D, C, B, A} lane order.
  function automatic logic [15:0] laneOrder(input logic [15:0] b);
    logic [15:0] o;
    o = 16'h0000;
    for (int k = 0; k < 4; k++)
    begin
      o[k]      = b[4 + k];   // RULE2
      o[4 + k]  = b[k];       // RULE2
      o[8 + k]  = b[11 - k];  // RULE2
      o[12 + k] = b[15 - k];  // RULE2
    end
    return o;
  endfunction

  function automatic switch_cfg_t decodeCfg(input logic [7:0] r [REG_COUNT]);
    switch_cfg_t c;
    c.hsEnable              = r[IDX_HS][ENABLE_BIT];
    c.hsSource              = r[IDX_HS][SRC_LSB +: 2];
    c.auxEnable             = r[IDX_AUX][ENABLE_BIT];
    c.commonSideLinesSource = r[IDX_AUX][SRC_LSB +: 2];
    c.inputTermEnable       = r[IDX_RX][TERM_IN_BIT];
    c.termPulseOnSwitch     = laneOrder({r[IDX_PT2], r[IDX_PT1]});
    c.laneBoostSelect       = laneOrder({r[IDX_EQ_CD], r[IDX_EQ_AB]});  // RULE1
    c.outputEmphasisLevel   = r[IDX_TX][EMPH_LSB +: 2];                 // RULE3
    c.outputTermEnable      = r[IDX_TX][OTERM_BIT];                     // RULE4
    c.outputDriveCurrentSel = r[IDX_TX][CURR_BIT];                      // RULE5
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Strap pin synchroniser
  // ----------------------------------------------------------------
  strap_pins_t strapMeta_r;
  strap_pins_t strapSync_r;

  always_ff @(posedge clk)
  begin
    strapMeta_r <= strapPins;
    strapSync_r <= strapMeta_r;
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]  serReg_r   [REG_COUNT];
  logic [7:0]  serReg_nxt [REG_COUNT];
  logic [7:0]  appReg_r   [REG_COUNT];
  logic [7:0]  appReg_nxt [REG_COUNT];
  logic [7:0]  parReg     [REG_COUNT];
  logic [CW-1:0] delayCnt_r   [REG_COUNT];
  logic [CW-1:0] delayCnt_nxt [REG_COUNT];
  logic        serialSeen_r;
  logic        serialSeen_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  switch_cfg_t cfg_r;
  switch_cfg_t cfg_nxt;
  logic [3:0]  hit;

  always_comb
  begin
    hit = regIndex(serAddr);  // RULE18
    // Parallel set is rebuilt from the synchronised pins every cycle.
    parReg[IDX_HS]    = {1'b0, strapSync_r.strapHighspeedEnable, 4'h0,
                         strapSync_r.strapSourceSelect};                  // RULE7 RULE8 RULE9
    parReg[IDX_AUX]   = {2'h1, 4'h0, strapSync_r.strapSourceSelect};      // RULE10
    parReg[IDX_RX]    = 8'h01;                                            // RULE11
    parReg[IDX_PT1]   = 8'h00;                                            // RULE12
    parReg[IDX_PT2]   = 8'h00;                                            // RULE12
    parReg[IDX_EQ_AB] = {8{strapSync_r.strapBoostSelect}};                // RULE13
    parReg[IDX_EQ_CD] = {8{strapSync_r.strapBoostSelect}};                // RULE13
    parReg[IDX_TX]    = {4'h0, strapSync_r.strapEmphasisLevel,
                         strapSync_r.strapOutputTermEnable,
                         strapSync_r.strapDriveCurrentSel};               // RULE14 RULE15

    serialSeen_nxt = serialSeen_r | serWrite | serRead;                   // RULE6 RULE16
    rdata_nxt      = rdata_r;
    if (serRead)
      rdata_nxt = hit[3] ? serReg_r[hit[2:0]] : 8'h00;

    for (int i = 0; i < REG_COUNT; i++)
    begin
      serReg_nxt[i]   = serReg_r[i];
      appReg_nxt[i]   = appReg_r[i];
      delayCnt_nxt[i] = delayCnt_r[i];
      if (serWrite && hit[3] && hit[2:0] == 3'(i))
        serReg_nxt[i] = serWData & REG_MASK[i*8 +: 8];
      if (delayCnt_r[i] != '0)
      begin
        // The window runs out on its own; a write inside it only replaces the value.
        delayCnt_nxt[i] = delayCnt_r[i] - CW'(1);                         // RULE17
        if (delayCnt_r[i] == CW'(1))
          appReg_nxt[i] = serReg_nxt[i];                                  // RULE17
      end
      else if (serWrite && hit[3] && hit[2:0] == 3'(i))
      begin
        appReg_nxt[i]   = serReg_nxt[i];
        delayCnt_nxt[i] = CW'(UPDATE_DELAY);                              // RULE17
      end
    end

    // Strap values stand until the first serial event, then the serial set.
    cfg_nxt = serialSeen_r ? decodeCfg(appReg_r) : decodeCfg(parReg);     // RULE19 RULE16
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      serialSeen_r <= 1'b0;
      rdata_r      <= 8'h00;
      cfg_r        <= '0;
      for (int i = 0; i < REG_COUNT; i++)
      begin
        serReg_r[i]   <= REG_RESET[i*8 +: 8];
        appReg_r[i]   <= REG_RESET[i*8 +: 8];
        delayCnt_r[i] <= '0;
      end
    end
    else
    begin
      serialSeen_r <= serialSeen_nxt;
      rdata_r      <= rdata_nxt;
      cfg_r        <= cfg_nxt;
      for (int i = 0; i < REG_COUNT; i++)
      begin
        serReg_r[i]   <= serReg_nxt[i];
        appReg_r[i]   <= appReg_nxt[i];
        delayCnt_r[i] <= delayCnt_nxt[i];
      end
    end
  end

  assign serRData   = rdata_r;
  assign cfg        = cfg_r;
  assign serialMode = serialSeen_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence txWriteInWindow;
    serWrite && serAddr == ADDR_TX && delayCnt_r[IDX_TX] > CW'(1);
  endsequence

  sequence txHeld;
    appReg_r[IDX_TX] == $past(appReg_r[IDX_TX]) &&
    delayCnt_r[IDX_TX] == $past(delayCnt_r[IDX_TX]) - CW'(1);
  endsequence

  boost_lane_a: assert property (@(posedge clk) disable iff (rst)  // RULE1 RULE2
    serialSeen_r |=> cfg_r.laneBoostSelect[3:0] == $past(appReg_r[IDX_EQ_AB][7:4]) &&
                     cfg_r.laneBoostSelect[11] == $past(appReg_r[IDX_EQ_CD][0]))
    else $error("Boost bits reach the wrong lanes.");

  emphasis_map_a: assert property (@(posedge clk) disable iff (rst)  // RULE3
    serialSeen_r |=> cfg_r.outputEmphasisLevel == $past(appReg_r[IDX_TX][3:2]))
    else $error("Emphasis level does not follow its field.");

  term_current_a: assert property (@(posedge clk) disable iff (rst)  // RULE4 RULE5
    serialSeen_r |=> {cfg_r.outputTermEnable, cfg_r.outputDriveCurrentSel} ==
                     $past(appReg_r[IDX_TX][1:0]))
    else $error("Termination or current bit misplaced.");

  strap_follow_a: assert property (@(posedge clk) disable iff (rst)  // RULE7 RULE13 RULE14 RULE15
    !serialSeen_r |=> cfg_r.laneBoostSelect == {16{$past(strapSync_r.strapBoostSelect)}} &&
                      cfg_r.outputEmphasisLevel == $past(strapSync_r.strapEmphasisLevel) &&
                      cfg_r.outputDriveCurrentSel == $past(strapSync_r.strapDriveCurrentSel))
    else $error("Parallel set does not follow the strap pins.");

  strap_route_a: assert property (@(posedge clk) disable iff (rst)  // RULE8 RULE9 RULE10
    !serialSeen_r |=> cfg_r.hsSource == $past(strapSync_r.strapSourceSelect) &&
                      cfg_r.commonSideLinesSource == cfg_r.hsSource &&
                      cfg_r.hsEnable == $past(strapSync_r.strapHighspeedEnable))
    else $error("Strap routing wrong.");

  strap_fixed_a: assert property (@(posedge clk) disable iff (rst)  // RULE10 RULE11 RULE12
    !serialSeen_r |=> cfg_r.auxEnable && cfg_r.inputTermEnable &&
                      cfg_r.termPulseOnSwitch == 16'h0000)
    else $error("Parallel fixed values wrong.");

  serial_takeover_a: assert property (@(posedge clk) disable iff (rst)  // RULE6 RULE16
    (serWrite || serRead) |=> serialSeen_r [*2])
    else $error("Serial event did not lock out the straps.");

  window_hold_a: assert property (@(posedge clk) disable iff (rst)  // RULE17
    txWriteInWindow |=> txHeld)
    else $error("Write inside a window changed the output or restarted it.");

  window_end_a: assert property (@(posedge clk) disable iff (rst)  // RULE17
    (delayCnt_r[IDX_TX] == CW'(1)) |=> appReg_r[IDX_TX] == $past(serReg_nxt[IDX_TX]) &&
                                      delayCnt_r[IDX_TX] == '0)
    else $error("Last written value not applied at window end.");

  read_map_a: assert property (@(posedge clk) disable iff (rst)  // RULE18
    (serRead && serAddr == ADDR_EQ_CD) |=> serRData == $past(serReg_r[IDX_EQ_CD]))
    else $error("Read of the C/D boost register returned wrong data.");

endmodule

// file: host_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Host side: serial register engine and strap pin levels
// ----------------------------------------------------------------
module host_model (
  input  wire logic                    clk,
  output logic                         serWrite,
  output logic                         serRead,
  output logic [7:0]                   serAddr,
  output logic [7:0]                   serWData,
  output video_switch_pkg::strap_pins_t strapPins
);
  import video_switch_pkg::*;

  initial
  begin
    serWrite  = 1'b0;
    serRead   = 1'b0;
    serAddr   = 8'h00;
    serWData  = 8'h00;
    strapPins = '0;
  end

  // Released address and data are inverted so a stale value never looks live.
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    serWrite = wr;
    serRead  = ~wr;
    serAddr  = a;
    serWData = d;
    @(posedge clk);
    #1;
    serWrite = 1'b0;
    serRead  = 1'b0;
    serAddr  = ~a;
    serWData = ~d;
    // One idle edge keeps a following call from lowering and raising a strobe in one time step.
    @(posedge clk);
    #1;
  endtask

  // Straps are static levels with no strobe of any kind.
  task automatic straps(input strap_pins_t p);
    strapPins = p;
  endtask
endmodule

// file: video_switch_config_regs_tb.sv
`timescale 1ns/100ps
module video_switch_config_regs_tb;
  import video_switch_pkg::*;
  localparam int UD = 3;
  typedef struct packed { logic isCfg; logic mode; switch_cfg_t val; } note_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        readSeen = 1'b0;
  logic        cfgProbe = 1'b0;
  logic        serWrite, serRead, serialMode;
  logic [7:0]  serAddr, serWData, serRData;
  strap_pins_t strapPins;
  switch_cfg_t cfg;
  logic [7:0]  model [REG_COUNT];
  note_t       notes [$];
  int          mismatches = 0;
  int          nTests = 0;
  int          cycles = 0;

  always #2 clk = ~clk;

  video_switch_config_regs #(.UPDATE_DELAY(UD)) DUT (.clk(clk), .rst(rst), .serWrite(serWrite),
    .serRead(serRead), .serAddr(serAddr), .serWData(serWData), .serRData(serRData),
    .strapPins(strapPins), .cfg(cfg), .serialMode(serialMode));
  host_model host (.clk(clk), .serWrite(serWrite), .serRead(serRead), .serAddr(serAddr),
    .serWData(serWData), .strapPins(strapPins));

  // ----------------------------------------------------------------
  // Expected values
  // ----------------------------------------------------------------
  function automatic logic [15:0] laneMap(input logic [15:0] r);
    logic [15:0] m;
    m[3:0] = r[7:4];
    m[7:4] = r[3:0];
    for (int k = 0; k < 4; k++)
    begin
      m[8 + k]  = r[11 - k];
      m[12 + k] = r[15 - k];
    end
    return m;
  endfunction

  function automatic switch_cfg_t strapCfg(input strap_pins_t p);
    return {p.strapHighspeedEnable, p.strapSourceSelect,
            1'b1, p.strapSourceSelect, 1'b1, 16'h0000,
            {16{p.strapBoostSelect}}, p.strapEmphasisLevel,
            p.strapOutputTermEnable, p.strapDriveCurrentSel};
  endfunction

  function automatic switch_cfg_t serCfg();
    return {model[IDX_HS][ENABLE_BIT], model[IDX_HS][1:0], model[IDX_AUX][ENABLE_BIT],
            model[IDX_AUX][1:0], model[IDX_RX][TERM_IN_BIT],
            laneMap({model[IDX_PT2], model[IDX_PT1]}),
            laneMap({model[IDX_EQ_CD], model[IDX_EQ_AB]}),
            model[IDX_TX][3:2], model[IDX_TX][OTERM_BIT], model[IDX_TX][CURR_BIT]};
  endfunction

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    for (int i = 0; i < REG_COUNT; i++)
      if (REG_ADDRS[8*i +: 8] == a)
        model[i] = d & REG_MASK[8*i +: 8];
    host.access(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    switch_cfg_t v;
    v = '0;
    for (int i = 0; i < REG_COUNT; i++)
      if (REG_ADDRS[8*i +: 8] == a)
        v[7:0] = model[i];
    notes.push_back({1'b0, 1'b0, v});
    host.access(1'b0, a, 8'h00);
  endtask

  task automatic probe(input switch_cfg_t v, input logic m);
    notes.push_back({1'b1, m, v});
    cfgProbe = 1'b1;
    tick(1);
    cfgProbe = 1'b0;
  endtask

  task automatic resetModel();
    for (int i = 0; i < REG_COUNT; i++)
      model[i] = REG_RESET[8*i +: 8];
  endtask

  // ----------------------------------------------------------------
  // Monitor: each result is matched against the oldest note
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    note_t n;
    readSeen <= serRead;
    if (readSeen || cfgProbe)
    begin
      n = notes.pop_front();
      nTests++;
      if (n.isCfg && ({serialMode, cfg} !== {n.mode, n.val}))
      begin
        mismatches++;
        $display("ERROR cfg expected %h/%h seen %h/%h", n.mode, n.val, serialMode, cfg);
      end
      if (!n.isCfg && (serRData !== n.val[7:0]))
      begin
        mismatches++;
        $display("ERROR serRData expected %h seen %h", n.val[7:0], serRData);
      end
    end
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      finalReport();
    end
  end

  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    strap_pins_t p;
    switch_cfg_t x;
    void'($urandom(32'h151C));
    resetModel();
    tick(2);
    probe('0, 1'b0);
    tick(1);
    rst = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      p = 8'($urandom);
      p.strapSourceSelect = i[1:0];
      host.straps(p);
      tick(4);
      probe(strapCfg(p), 1'b0);
    end
    // The first access is a read, which must still count as a serial event.
    rd(ADDR_TX);
    tick(2);
    probe(serCfg(), 1'b1);
    p = ~p;
    host.straps(p);
    tick(4);
    probe(serCfg(), 1'b1);
    for (int i = 0; i < REG_COUNT; i++)
      rd(REG_ADDRS[8*i +: 8]);
    for (int i = 0; i < REG_COUNT; i++)
    begin
      wr(REG_ADDRS[8*i +: 8], 8'($urandom));
      rd(REG_ADDRS[8*i +: 8]);
    end
    wr(8'h15, 8'hFF);
    rd(8'h15);
    tick(UD + 3);
    probe(serCfg(), 1'b1);
    for (int e = 0; e < 4; e++)
    begin
      wr(ADDR_TX, {4'h0, e[1:0], e[0], ~e[0]});
      tick(UD + 3);
      probe(serCfg(), 1'b1);
    end
    // The second write lands inside the window: it must wait, yet not stretch it.
    // With a window of three cycles the new value is applied between the two probes.
    wr(ADDR_TX, 8'h0D);
    x = serCfg();
    wr(ADDR_TX, 8'h02);
    probe(x, 1'b1);
    probe(serCfg(), 1'b1);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    resetModel();
    tick(4);
    probe(strapCfg(p), 1'b0);
    rd(ADDR_EQ_AB);
    tick(2);
    finalReport();
  end
endmodule
